/* File: rtl/meter_regs_pkg.sv */
package meter_regs_pkg;
  localparam logic [4:0] MODE_ADDR = 5'h06;
  localparam logic [15:0] MODE_RESET = 16'h000c;
  localparam int CMD_BITS = 8;
  localparam int CMD_RW_BIT = 7;
  localparam int CMD_ADDR_MSB = 4;
  localparam int MODE_BITS = 16;
  localparam int OTHER_BITS = 8;
  localparam int TEMP_BIT = 5;
  localparam int SRST_BIT = 6;
  localparam int CLK_PERIOD_NS = 40;
  localparam int SRST_TIME_NS = 18000;
  localparam int SRST_CYCLES = (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RATE_BASE = 128;

  // mode register layout, bit 15 first
  typedef struct packed {
    logic factory_test;
    logic [1:0] waveform_source;
    logic [1:0] waveform_rate_select;
    logic input_swap;
    logic second_input_short;
    logic first_input_short;
    logic calibration_select;
    logic soft_chip_reset;
    logic thermal_conversion_start;
    logic converters_power_down;
    logic dip_detect_disable;
    logic freq_output_disable;
    logic power_lowpass_bypass;
    logic ch1_highpass_bypass;
  } mode_t;

  // one register write handed across from the link
  typedef struct packed {
    logic [4:0] target_register_index;
    logic [15:0] data;
  } wr_req_t;

  // bits moved by the data phase of a given register
  function automatic logic [4:0] xfer_bits(input logic [4:0] idx);
    xfer_bits = (idx == MODE_ADDR) ? 5'(MODE_BITS) : 5'(OTHER_BITS);
  endfunction

  // master clocks between waveform updates
  function automatic logic [10:0] rate_period(input logic [1:0] code);
    rate_period = 11'(RATE_BASE << code);
  endfunction
endpackage

/* File: rtl/bit_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module bit_sync import meter_regs_pkg::*; #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // level in and out
  input wire logic d,
  output logic q
);
  logic meta_r;

  // two stages; only the second is read
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/rate_strobe.sv */
`timescale 1ns/1ps
`default_nettype none
module rate_strobe import meter_regs_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // selected rate code
  input wire logic [1:0] code,
  // one-cycle update strobe
  output logic tick
);
  logic [10:0] cnt_r;
  logic [10:0] cnt_nxt;
  logic [10:0] last;

  // period changes apply to the running count at once; a count at or past the new end wraps on the next clock
  assign last = rate_period(code) - 11'h001;
  assign cnt_nxt = (cnt_r >= last) ? 11'h000 : cnt_r + 11'h001;

  // period counter
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= 11'h000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // strobe on wrap
  always_ff @(posedge clk) begin
    if (rst) begin
      tick <= 1'b0;
    end else begin
      tick <= (cnt_r >= last);
    end
  end
endmodule
`default_nettype wire

/* File: rtl/meter_command_and_mode_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module meter_command_and_mode_regs import meter_regs_pkg::*; (
  // system clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  // datapath hooks on ref_clk
  input wire logic temp_conv_done,
  input wire logic energy_pulse_raw,
  input wire logic dip_raw,
  // configuration outputs
  output logic ch1_highpass_bypass,
  output logic power_lowpass_bypass,
  output logic freq_output_disable,
  output logic dip_detect_disable,
  output logic converters_power_down,
  output logic thermal_conversion_start,
  output logic soft_chip_reset,
  output logic calibration_select,
  output logic first_input_short,
  output logic second_input_short,
  output logic input_swap,
  // gated datapath results
  output logic energy_pulse_output,
  output logic dip_event,
  output logic waveform_update
);

  // link phases
  typedef enum logic [1:0] {
    PH_CMD = 2'b01,
    PH_DATA = 2'b10
  } phase_t;

  // ---------------- link domain (sclk) ----------------
  phase_t phase_r;
  logic [4:0] bit_cnt_r;
  logic [7:0] cmd_r;
  logic [7:0] cmd_nxt;
  logic is_write_r;
  logic [4:0] idx_r;
  logic [4:0] width_r;
  logic [15:0] shift_r;
  logic [15:0] shift_nxt;
  logic dout_r;
  logic wr_tgl_r;
  wr_req_t wr_req_r;
  logic cmd_last;
  logic data_last;

  // ---------------- system domain (ref_clk) ----------------
  mode_t mode_r;
  logic [15:0] hold_r;
  logic cs_n_s;
  logic wr_tgl_s;
  logic wr_seen_r;
  logic wr_pulse;
  logic [8:0] srst_cnt_r;
  logic srst_busy;
  logic pulse_r;
  logic dip_r;
  logic tick;

  // next shift values share one bit of input
  assign cmd_nxt = {cmd_r[6:0], din};
  assign shift_nxt = {shift_r[14:0], din};
  assign cmd_last = (phase_r == PH_CMD) && (bit_cnt_r == 5'(CMD_BITS - 1));
  assign data_last = (phase_r == PH_DATA) && (bit_cnt_r == width_r - 5'h01);

  // phase sequencing; a frame end returns to command wait
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      phase_r <= PH_CMD;
      bit_cnt_r <= 5'h00;
    end else begin
      case (phase_r)
        PH_CMD: begin
          if (cmd_last) begin
            phase_r <= PH_DATA;
            bit_cnt_r <= 5'h00;
          end else begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
          end
        end
        PH_DATA: begin
          if (data_last) begin
            phase_r <= PH_CMD;
            bit_cnt_r <= 5'h00;
          end else begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
          end
        end
        default: begin
          phase_r <= PH_CMD;
          bit_cnt_r <= 5'h00;
        end
      endcase
    end
  end

  // command byte capture; kept private, no read path exists
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      cmd_r <= 8'h00;
    end else if (phase_r == PH_CMD) begin
      cmd_r <= cmd_nxt;
    end
  end

  // decode of the finished command byte
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      is_write_r <= 1'b0;
      idx_r <= 5'h00;
      width_r <= 5'(OTHER_BITS);
    end else if (cmd_last) begin
      is_write_r <= cmd_nxt[CMD_RW_BIT];
      idx_r <= cmd_nxt[CMD_ADDR_MSB:0];
      width_r <= xfer_bits(cmd_nxt[CMD_ADDR_MSB:0]);
    end
  end

  // data shifter: loads read data at command end, then shifts msb first
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      shift_r <= 16'h0000;
    end else if (cmd_last) begin
      if (cmd_nxt[CMD_ADDR_MSB:0] == MODE_ADDR) begin
        shift_r <= hold_r;
      end else begin
        shift_r <= 16'h0000;
      end
    end else if (phase_r == PH_DATA) begin
      shift_r <= shift_nxt;
    end
  end

  // read data leaves on the falling edge for the host's rising sample
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      dout_r <= 1'b0;
    end else begin
      dout_r <= (phase_r == PH_DATA) && !is_write_r && shift_r[15];
    end
  end

  assign dout = dout_r;

  // completed writes: data and index are captured on the same edge that flips the toggle announcing them
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      wr_tgl_r <= 1'b0;
      wr_req_r <= '0;
    end else if (data_last && is_write_r) begin
      wr_tgl_r <= ~wr_tgl_r;
      wr_req_r.target_register_index <= idx_r;
      wr_req_r.data <= shift_nxt;
    end
  end

  // ---------------- crossings ----------------
  // frame select level into the system domain
  bit_sync #(
    .RESET_VAL(1'b1)
  ) u_cs_sync (
    .clk(ref_clk),
    .rst(rst),
    .d(cs_n),
    .q(cs_n_s)
  );

  // write toggle into the system domain
  bit_sync #(
    .RESET_VAL(1'b0)
  ) u_wr_sync (
    .clk(ref_clk),
    .rst(rst),
    .d(wr_tgl_r),
    .q(wr_tgl_s)
  );

  // toggle edge becomes a single write pulse
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_seen_r <= 1'b0;
    end else begin
      wr_seen_r <= wr_tgl_s;
    end
  end

  assign wr_pulse = (wr_tgl_s != wr_seen_r) && !srst_busy;

  // read copy of mode, frozen while a frame is open so the link sees a stable word
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hold_r <= MODE_RESET;
    end else if (cs_n_s) begin
      hold_r <= mode_r;
    end
  end

  // ---------------- mode register ----------------
  // written from the link; thermal start clears itself when conversion ends
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_r <= MODE_RESET;
    end else if (wr_pulse && wr_req_r.target_register_index == MODE_ADDR) begin
      if (wr_req_r.data[SRST_BIT]) begin
        mode_r <= MODE_RESET;
      end else begin
        mode_r <= wr_req_r.data;
      end
    end else if (srst_busy) begin
      mode_r <= MODE_RESET;
    end else if (temp_conv_done) begin
      mode_r.thermal_conversion_start <= 1'b0;
    end
  end

  // ---------------- soft reset timer ----------------
  // chip stays in reset for the host's wait time, writes are dropped meanwhile
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      srst_cnt_r <= 9'h000;
    end else if (wr_pulse && wr_req_r.target_register_index == MODE_ADDR && wr_req_r.data[SRST_BIT]) begin
      srst_cnt_r <= 9'(SRST_CYCLES);
    end else if (srst_cnt_r != 9'h000) begin
      srst_cnt_r <= srst_cnt_r - 9'h001;
    end
  end

  assign srst_busy = (srst_cnt_r != 9'h000);
  assign soft_chip_reset = srst_busy;

  // ---------------- configuration outputs ----------------
  // direct copies of mode flip-flops
  assign ch1_highpass_bypass = mode_r.ch1_highpass_bypass;
  assign power_lowpass_bypass = mode_r.power_lowpass_bypass;
  assign freq_output_disable = mode_r.freq_output_disable;
  assign dip_detect_disable = mode_r.dip_detect_disable;
  assign converters_power_down = mode_r.converters_power_down;
  assign thermal_conversion_start = mode_r.thermal_conversion_start;
  assign calibration_select = mode_r.calibration_select;
  assign first_input_short = mode_r.first_input_short;
  assign second_input_short = mode_r.second_input_short;
  assign input_swap = mode_r.input_swap;

  // energy pulses pass only while the output is enabled
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pulse_r <= 1'b0;
    end else begin
      pulse_r <= energy_pulse_raw && !mode_r.freq_output_disable;
    end
  end

  assign energy_pulse_output = pulse_r;

  // dip reports are suppressed while detection is off
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dip_r <= 1'b0;
    end else begin
      dip_r <= dip_raw && !mode_r.dip_detect_disable;
    end
  end

  assign dip_event = dip_r;

  // waveform update pacing from the master clock
  rate_strobe u_rate (
    .clk(ref_clk),
    .rst(rst || srst_busy),
    .code(mode_r.waveform_rate_select),
    .tick(tick)
  );

  assign waveform_update = tick;

endmodule
`default_nettype wire

/* File: dv/meter_props.sv */
`timescale 1ns/1ps
`default_nettype none
module meter_props import meter_regs_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // datapath inputs
  input wire logic energy_pulse_raw,
  input wire logic dip_raw,
  input wire logic temp_conv_done,
  // watched outputs
  input wire logic freq_output_disable,
  input wire logic dip_detect_disable,
  input wire logic calibration_select,
  input wire logic thermal_conversion_start,
  input wire logic soft_chip_reset,
  input wire logic energy_pulse_output,
  input wire logic dip_event,
  input wire logic waveform_update
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [9:0] srst_cnt_r;
  // cycles spent in the current soft reset
  always_ff @(posedge ref_clk) begin
    srst_cnt_r <= (rst || !soft_chip_reset) ? 10'h000 : srst_cnt_r + 10'h001;
  end
  reset_vals_a: assert property ($past(rst) |-> freq_output_disable && dip_detect_disable)
    else $error("mode outputs wrong after reset");
  pulse_gate_a: assert property (energy_pulse_output == ($past(energy_pulse_raw) && !$past(freq_output_disable)))
    else $error("energy pulse gating wrong");
  dip_gate_a: assert property (dip_event == ($past(dip_raw) && !$past(dip_detect_disable)))
    else $error("dip gating wrong");
  temp_clear_a: assert property (thermal_conversion_start && temp_conv_done |=> !thermal_conversion_start)
    else $error("thermal start not cleared");
  srst_len_a: assert property ($fell(soft_chip_reset) |-> srst_cnt_r == 10'(SRST_CYCLES))
    else $error("soft reset too short");
  srst_max_a: assert property (soft_chip_reset |-> srst_cnt_r < 10'(SRST_CYCLES))
    else $error("soft reset too long");
  srst_mode_a: assert property (soft_chip_reset |=> freq_output_disable && !calibration_select)
    else $error("mode not at reset value in soft reset");
  wave_gap_a: assert property (waveform_update |=> !waveform_update [*8])
    else $error("waveform strobe too close");
endmodule
bind meter_command_and_mode_regs meter_props props (.*);
`default_nettype wire

/* File: dv/host_link_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_link_model import meter_regs_pkg::*; (
  // link pins
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout
);
  // link idle, clock stopped
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // one frame: command byte first, then nb data bits, msb first
  task automatic frame(input logic [7:0] cmd, input int nb, input logic [15:0] wd, output logic [15:0] rd);
    logic [23:0] sh;
    sh = {cmd & 8'h9f, wd << (16 - nb)};
    rd = 16'h0000;
    cs_n = 1'b0;
    #11;
    for (int i = 0; i < 8 + nb; i++) begin
      din = sh[23 - i];
      #7.5 sclk = 1'b1;
      if (i >= 8) rd = {rd[14:0], dout};
      #7.5 sclk = 1'b0;
    end
    #11 cs_n = 1'b1;
    din = ~din; // released line does not hold its last value
    #130; // select stays high over three system clocks before any next frame
  endtask
endmodule
`default_nettype wire

/* File: dv/meter_command_and_mode_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module meter_command_and_mode_regs_tb import meter_regs_pkg::*;;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic temp_conv_done = 1'b0;
  logic energy_pulse_raw = 1'b1;
  logic dip_raw = 1'b1;
  logic sclk, cs_n, din, dout, ch1_highpass_bypass, power_lowpass_bypass, freq_output_disable;
  logic dip_detect_disable, converters_power_down, thermal_conversion_start, soft_chip_reset;
  logic calibration_select, first_input_short, second_input_short, input_swap;
  logic energy_pulse_output, dip_event, waveform_update;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [15:0] rd;
  // mode value written beside the outputs it should give
  logic [27:0] rows [12] = '{28'h0001c01, 28'h0002c02, 28'h0004804, 28'h0008408, 28'h0010c10, 28'h0020c20,
    28'h0080c40, 28'h0100c80, 28'h0200d00, 28'h0400e00, 28'h0800c00, 28'h0000c00};
  wire logic [11:0] obs = {dip_event, energy_pulse_output, input_swap, second_input_short, first_input_short,
    calibration_select, thermal_conversion_start, converters_power_down, dip_detect_disable,
    freq_output_disable, power_lowpass_bypass, ch1_highpass_bypass};
  meter_command_and_mode_regs dut (.*);
  host_link_model host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
  always #20 ref_clk = ~ref_clk;
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // mode write, then let it cross
  task automatic wr(input logic [15:0] v);
    host.frame({1'b1, 2'b00, MODE_ADDR}, 16, v, rd);
    repeat (6) @(negedge ref_clk);
  endtask
  task automatic rd_mode(input logic [15:0] exp);
    host.frame({1'b0, 2'b00, MODE_ADDR}, 16, 16'h0000, rd);
    chk(rd, exp);
  endtask
  // cycles between two waveform strobes
  task automatic gap(input int exp);
    int n;
    n = 0;
    while (waveform_update !== 1'b1) @(negedge ref_clk);
    @(negedge ref_clk);
    while (waveform_update !== 1'b1) begin
      n++;
      @(negedge ref_clk);
    end
    chk(16'(n + 1), 16'(exp));
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // watchdog
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk(16'(obs), 16'h000c);
    rd_mode(16'h000c);
    foreach (rows[i]) begin
      wr(rows[i][27:12]);
      chk(16'(obs), 16'(rows[i][11:0]));
      rd_mode(rows[i][27:12]);
    end
    // other index: 8-bit data, mode untouched
    host.frame(8'h87, 8, 16'h00ff, rd);
    host.frame(8'h07, 8, 16'h0000, rd);
    chk(rd, 16'h0000);
    rd_mode(16'h0000);
    wr(16'h0020);
    temp_conv_done = 1'b1;
    @(negedge ref_clk);
    temp_conv_done = 1'b0;
    @(negedge ref_clk);
    chk(16'(thermal_conversion_start), 16'h0000);
    gap(128);
    wr(16'h0800);
    gap(256);
    wr(16'h1000);
    gap(512);
    wr(16'h0841);
    chk(16'(soft_chip_reset), 16'h0001);
    chk(16'(obs), 16'h000c);
    wr(16'h0001);
    #(SRST_TIME_NS);
    chk(16'(soft_chip_reset), 16'h0000);
    rd_mode(16'h000c);
    // reset in mid-run brings mode back to its reset value
    wr(16'h0081);
    rst = 1'b1;
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk(16'(obs), 16'h000c);
    rd_mode(16'h000c);
    wrap_up();
  end
endmodule
`default_nettype wire
